/* bfs_map.svh */
// Constants of the buck fault supervisor: times, counts, offsets, fields
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH

// ****************************************************************
// Clock and times
// ****************************************************************
`define BFS_CLK_NS          50
`define BFS_OK_ASSERT_NS    120000000
`define BFS_OK_DEASSERT_NS  150000
`define BFS_HICCUP_NS       60000000
`define BFS_SOFT_START_NS   8000000
`define BFS_DEAD_NS         12
`define BFS_BLANK_NS        100
`define BFS_DEAD_WAIT_NS    500
// Least time in whole cycles, never below one
`define BFS_CYC(ns) \
  ((((ns) + `BFS_CLK_NS - 1) / `BFS_CLK_NS) < 1 ? 1 : \
   (((ns) + `BFS_CLK_NS - 1) / `BFS_CLK_NS))

// ****************************************************************
// Counts and widths
// ****************************************************************
`define BFS_OC_FAULT_CNT    3'h7
`define BFS_OC_ZERO         3'h0
`define BFS_OC_ONE          3'h1
`define BFS_TMR_W           22
`define BFS_TMR_ZERO        22'h0
`define BFS_SHORT_W         4
`define BFS_SHORT_ZERO      4'h0
`define BFS_SHORT_ONE       4'h1

// ****************************************************************
// Synchroniser lanes of the comparator, pin, PWM and oscillator inputs
// ****************************************************************
`define BFS_NIN             12
`define BFS_IN_DIS_N        0
`define BFS_IN_VIN_UPPER    1
`define BFS_IN_VIN_LOWER    2
`define BFS_IN_REG_OK       3
`define BFS_IN_OUT_REACHED  4
`define BFS_IN_FB_WINDOW    5
`define BFS_IN_OVER_TEMP    6
`define BFS_IN_HS_OC        7
`define BFS_IN_LS_OC        8
`define BFS_IN_PWM_HS       9
`define BFS_IN_OSC_TICK     10
`define BFS_IN_PHASE_LOW    11

// ****************************************************************
// Register map and fields
// ****************************************************************
`define BFS_ADDR_CTRL       12'h000
`define BFS_ADDR_STATUS     12'h004
`define BFS_CTRL_RESET      2'h1
`define BFS_CTRL_ENABLE     0
`define BFS_CTRL_FIXED_DEAD 1
`define BFS_ST_STATE_LSB    0
`define BFS_ST_OK           3
`define BFS_ST_INPUT_OK     4
`define BFS_ST_RETRY        5
`define BFS_ST_HS_GATE      6
`define BFS_ST_LS_GATE      7
`define BFS_ST_HS_CNT_LSB   8
`define BFS_ST_LS_CNT_LSB   12

`endif

/* bfs_pkg.sv */
// Types shared by the buck fault supervisor
package bfs_pkg;
  typedef enum logic [2:0]
  {
    BFS_OFF        = 3'h0,
    BFS_LOCKOUT    = 3'h1,
    BFS_SOFT_START = 3'h2,
    BFS_RUN        = 3'h3,
    BFS_HICCUP     = 3'h4
  } bfs_state_t;
endpackage

/* bfs_buck_fault_supervisor.sv */
// Supervisor of a synchronous buck controller: lockout, gates, faults, ok flag
`timescale 1ns/1ps
`include "bfs_map.svh"

module bfs_buck_fault_supervisor #(
  parameter int unsigned OK_ASSERT_CYC = `BFS_CYC(`BFS_OK_ASSERT_NS),
  parameter int unsigned HICCUP_CYC    = `BFS_CYC(`BFS_HICCUP_NS),
  parameter int unsigned SOFT_CYC      = `BFS_CYC(`BFS_SOFT_START_NS)
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  input  wire logic               disable_input_n,
  input  wire logic               vin_above_upper,
  input  wire logic               vin_above_lower,
  input  wire logic               regulator_ok,
  input  wire logic               output_reached,
  input  wire logic               feedback_sense_in_window,
  input  wire logic               over_temp,
  input  wire logic               hs_overcurrent,
  input  wire logic               ls_overcurrent,
  input  wire logic               pwm_high_request,
  input  wire logic               osc_tick,
  input  wire logic               phase_low,
  output logic                    high_side_gate,
  output logic                    low_side_gate,
  output logic                    internal_regulator_en,
  output logic                    soft_start_active,
  output logic                    output_ok_flag_o,
  output logic                    output_ok_flag_oe,
  output bfs_pkg::bfs_state_t     supervisor_state
);
  import bfs_pkg::*;

  localparam int unsigned DEASSERT_CYC = `BFS_CYC(`BFS_OK_DEASSERT_NS);
  localparam int unsigned DEAD_CYC     = `BFS_CYC(`BFS_DEAD_NS);
  localparam int unsigned BLANK_CYC    = `BFS_CYC(`BFS_BLANK_NS);
  localparam int unsigned DEAD_WAIT    = `BFS_CYC(`BFS_DEAD_WAIT_NS);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // True once a counter started at zero has run the given cycles
  function automatic logic tmr_done(input logic [31:0] c,
                                    input int unsigned lim);
    tmr_done = (c + 32'h1) >= lim;
  endfunction

  // Up on a tripped cycle, down on a clean one, within 0..7
  function automatic logic [2:0] oc_step(input logic [2:0] c,
                                         input logic       trip);
    if (trip)
      oc_step = (c == `BFS_OC_FAULT_CNT) ? c : c + `BFS_OC_ONE;
    else
      oc_step = (c == `BFS_OC_ZERO) ? c : c - `BFS_OC_ONE;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [`BFS_NIN-1:0] sync1_reg;
  logic [`BFS_NIN-1:0] sync2_reg;
  logic                tick_d_reg;
  wire  [`BFS_NIN-1:0] raw_in = {phase_low, osc_tick, pwm_high_request,
                                 ls_overcurrent, hs_overcurrent, over_temp,
                                 feedback_sense_in_window, output_reached,
                                 regulator_ok, vin_above_lower,
                                 vin_above_upper, disable_input_n};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      tick_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg  <= raw_in;
      sync2_reg  <= sync1_reg;
      tick_d_reg <= sync2_reg[`BFS_IN_OSC_TICK];
    end

  wire dis_n_s    = sync2_reg[`BFS_IN_DIS_N];
  wire reg_ok_s   = sync2_reg[`BFS_IN_REG_OK];
  wire hot_s      = sync2_reg[`BFS_IN_OVER_TEMP];
  wire pwm_s      = sync2_reg[`BFS_IN_PWM_HS];
  wire phase_lo_s = sync2_reg[`BFS_IN_PHASE_LOW];
  wire cycle_start = sync2_reg[`BFS_IN_OSC_TICK] & ~tick_d_reg;

  // ****************************************************************
  // Registers over APB
  // ****************************************************************
  logic [1:0]  ctrl_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  wire         sel_ctrl   = (paddr == `BFS_ADDR_CTRL);
  wire         sel_status = (paddr == `BFS_ADDR_STATUS);
  wire         setup      = psel & ~penable;
  wire         wr_ctrl    = psel & penable & pwrite & sel_ctrl;
  wire         sw_enable  = ctrl_reg[`BFS_CTRL_ENABLE];
  wire         fixed_dead = ctrl_reg[`BFS_CTRL_FIXED_DEAD];
  wire [31:0]  status_word;
  wire [31:0]  rd_mux = sel_ctrl   ? {30'h0, ctrl_reg} :
                        sel_status ? status_word : 32'h0;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg    <= `BFS_CTRL_RESET;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[1:0];
      if (setup)
      begin
        prdata_reg  <= pwrite ? 32'h0 : rd_mux;
        pslverr_reg <= ~(sel_ctrl | (sel_status & ~pwrite));
      end
    end

  assign pready  = 1'b1;
  assign pslverr = pslverr_reg & psel & penable;
  assign prdata  = prdata_reg;

  // ****************************************************************
  // Supervisor state
  // ****************************************************************
  bfs_state_t               state_reg;
  bfs_state_t               state_next;
  logic                     input_ok_reg;
  logic                     retry_reg;
  logic [`BFS_TMR_W-1:0]    tmr_reg;
  logic [2:0]               hs_cnt_reg;
  logic [2:0]               ls_cnt_reg;
  logic                     hs_trip_reg;
  logic                     ls_trip_reg;

  wire input_ok_next = input_ok_reg ? sync2_reg[`BFS_IN_VIN_LOWER]
                                    : sync2_reg[`BFS_IN_VIN_UPPER];
  wire shutdown = ~dis_n_s | ~reg_ok_s | ~sw_enable;
  wire lockout  = ~input_ok_reg | hot_s;
  wire switching = (state_reg == BFS_SOFT_START) | (state_reg == BFS_RUN);
  wire judge     = switching & cycle_start;
  wire [2:0] hs_cnt_next = oc_step(hs_cnt_reg, hs_trip_reg);
  wire [2:0] ls_cnt_next = oc_step(ls_cnt_reg, ls_trip_reg);
  wire fault = judge & ((hs_cnt_next == `BFS_OC_FAULT_CNT) |
                        (ls_cnt_next == `BFS_OC_FAULT_CNT) |
                        (retry_reg & (hs_trip_reg | ls_trip_reg)));
  wire tmr_end = (state_reg == BFS_HICCUP)
                 ? tmr_done(32'(tmr_reg), HICCUP_CYC)
                 : tmr_done(32'(tmr_reg), SOFT_CYC);

  always_comb
  begin
    state_next = state_reg;
    if (shutdown)
      state_next = BFS_OFF;
    else if (lockout)
      state_next = BFS_LOCKOUT;
    else
      unique case (state_reg)
        BFS_OFF, BFS_LOCKOUT:
          state_next = BFS_SOFT_START;
        BFS_SOFT_START:
          if (fault)
            state_next = BFS_HICCUP;
          else if (tmr_end)
            state_next = BFS_RUN;
        BFS_RUN:
          if (fault)
            state_next = BFS_HICCUP;
        BFS_HICCUP:
          if (tmr_end)
            state_next = BFS_SOFT_START;
        default:
          state_next = BFS_OFF;
      endcase
  end

  wire state_change = (state_next != state_reg);
  wire clear_cnt    = (state_reg == BFS_OFF) | (state_reg == BFS_LOCKOUT);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_reg    <= BFS_OFF;
      input_ok_reg <= 1'b0;
      retry_reg    <= 1'b0;
      tmr_reg      <= `BFS_TMR_ZERO;
      hs_cnt_reg   <= `BFS_OC_ZERO;
      ls_cnt_reg   <= `BFS_OC_ZERO;
    end
    else
    begin
      state_reg    <= state_next;
      input_ok_reg <= input_ok_next;
      tmr_reg      <= state_change ? `BFS_TMR_ZERO : tmr_reg + 22'h1;
      if (clear_cnt | state_next == BFS_OFF)
      begin
        hs_cnt_reg <= `BFS_OC_ZERO;
        ls_cnt_reg <= `BFS_OC_ZERO;
      end
      else if (judge)
      begin
        hs_cnt_reg <= hs_cnt_next;
        ls_cnt_reg <= ls_cnt_next;
      end
      if (state_reg == BFS_HICCUP && state_next == BFS_SOFT_START)
        retry_reg <= 1'b1;
      else if (judge | ~switching)
        retry_reg <= 1'b0;
    end

  // ****************************************************************
  // Gate sequencing, blanking and overcurrent sensing
  // ****************************************************************
  logic                    hs_gate_reg;
  logic                    ls_gate_reg;
  logic                    hs_cut_reg;
  logic [`BFS_SHORT_W-1:0] dead_reg;
  logic [`BFS_SHORT_W-1:0] blank_reg;

  wire blank_done = tmr_done(32'(blank_reg), BLANK_CYC);
  wire hs_trip_set = hs_gate_reg & blank_done &
                     sync2_reg[`BFS_IN_HS_OC];
  wire ls_trip_set = ls_gate_reg & blank_done &
                     sync2_reg[`BFS_IN_LS_OC];
  wire gate_run = switching & ~state_change;
  wire want_hs  = gate_run & pwm_s & ~hs_cut_reg & ~hs_trip_set;
  // Low side stays on after its own trip: it only yields to a high-side request or a change of state
  wire want_ls  = gate_run & ~pwm_s;
  wire both_off = ~hs_gate_reg & ~ls_gate_reg;
  wire dead_done = tmr_done(32'(dead_reg), DEAD_CYC);
  // Adaptive wait is capped so a stuck phase sense cannot stall switching
  wire ls_may_on = fixed_dead ? dead_done
                 : (phase_lo_s & dead_done) |
                   tmr_done(32'(dead_reg), DEAD_WAIT);
  wire hs_on  = both_off & want_hs & dead_done;
  wire ls_on  = both_off & want_ls & ls_may_on;
  wire [`BFS_SHORT_W-1:0] dead_inc =
    (dead_reg == '1) ? dead_reg : dead_reg + `BFS_SHORT_ONE;
  wire [`BFS_SHORT_W-1:0] blank_inc =
    (blank_reg == '1) ? blank_reg : blank_reg + `BFS_SHORT_ONE;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hs_gate_reg <= 1'b0;
      ls_gate_reg <= 1'b0;
      hs_cut_reg  <= 1'b0;
      hs_trip_reg <= 1'b0;
      ls_trip_reg <= 1'b0;
      dead_reg    <= `BFS_SHORT_ZERO;
      blank_reg   <= `BFS_SHORT_ZERO;
    end
    else
    begin
      hs_gate_reg <= hs_on | (hs_gate_reg & want_hs);
      ls_gate_reg <= ls_on | (ls_gate_reg & want_ls);
      dead_reg    <= both_off ? dead_inc : `BFS_SHORT_ZERO;
      blank_reg   <= (hs_on | ls_on) ? `BFS_SHORT_ZERO : blank_inc;
      // A trip in the cycle that consumes the flag still counts
      hs_cut_reg  <= hs_trip_set | (hs_cut_reg & ~cycle_start);
      hs_trip_reg <= hs_trip_set | (hs_trip_reg & ~cycle_start);
      ls_trip_reg <= ls_trip_set | (ls_trip_reg & ~cycle_start);
    end

  assign high_side_gate        = hs_gate_reg;
  assign low_side_gate         = ls_gate_reg;
  assign internal_regulator_en = dis_n_s;
  assign soft_start_active     = (state_reg == BFS_SOFT_START);
  assign supervisor_state      = state_reg;

  // ****************************************************************
  // Output-ok flag with assert and deassert delays
  // ****************************************************************
  logic                  ok_reg;
  logic [`BFS_TMR_W-1:0] ok_tmr_reg;

  wire oc_seen = hs_trip_reg | ls_trip_reg |
                 (hs_cnt_reg != `BFS_OC_ZERO) |
                 (ls_cnt_reg != `BFS_OC_ZERO);
  wire all_good = (state_reg == BFS_RUN)
                & sync2_reg[`BFS_IN_OUT_REACHED]
                & sync2_reg[`BFS_IN_FB_WINDOW]
                & input_ok_reg
                & ~oc_seen
                & ~hot_s;
  wire ok_change = ok_reg ? ~all_good : all_good;
  wire ok_end    = ok_reg ? tmr_done(32'(ok_tmr_reg), DEASSERT_CYC)
                          : tmr_done(32'(ok_tmr_reg), OK_ASSERT_CYC);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ok_reg     <= 1'b0;
      ok_tmr_reg <= `BFS_TMR_ZERO;
    end
    else if (!ok_change)
      ok_tmr_reg <= `BFS_TMR_ZERO;
    else if (ok_end)
    begin
      ok_reg     <= ~ok_reg;
      ok_tmr_reg <= `BFS_TMR_ZERO;
    end
    else
      ok_tmr_reg <= ok_tmr_reg + 22'h1;

  // Open drain: the pin is only ever pulled low
  assign output_ok_flag_o  = 1'b0;
  assign output_ok_flag_oe = ~ok_reg;

  assign status_word = {17'h0, ls_cnt_reg, 1'b0, hs_cnt_reg,
                        ls_gate_reg, hs_gate_reg, retry_reg,
                        input_ok_reg, ok_reg, state_reg};
endmodule

/* bfs_assertions.sv */
// Port-level checks of the buck fault supervisor, bound to its top module
`timescale 1ns/1ps
module bfs_assertions #(
  parameter int unsigned OK_ASSERT_CYC = 20,
  parameter int unsigned HICCUP_CYC    = 30,
  parameter int unsigned SOFT_CYC      = 40
)(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                disable_input_n,
  input wire logic                vin_above_lower,
  input wire logic                regulator_ok,
  input wire logic                output_reached,
  input wire logic                feedback_sense_in_window,
  input wire logic                over_temp,
  input wire logic                hs_overcurrent,
  input wire logic                high_side_gate,
  input wire logic                low_side_gate,
  input wire logic                internal_regulator_en,
  input wire logic                soft_start_active,
  input wire logic                output_ok_flag_oe,
  input wire bfs_pkg::bfs_state_t supervisor_state
);
  import bfs_pkg::*;
  // Slack for the input synchronisers and the flag flop
  localparam int ASSERT_MIN   = OK_ASSERT_CYC - 6;
  localparam int DEASSERT_LIM = 3005;
  bfs_state_t  st_q;
  logic [15:0] dwell;
  logic [15:0] good_cnt;
  logic [15:0] bad_cnt;
  logic        good_now;
  assign good_now = supervisor_state == BFS_RUN && output_reached &&
                    feedback_sense_in_window && !over_temp;
  // ****************************************************************
  // Dwell and persistence counters
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q     <= BFS_OFF;
      dwell    <= 16'h0;
      good_cnt <= 16'h0;
      bad_cnt  <= 16'h0;
    end
    else
    begin
      st_q     <= supervisor_state;
      dwell    <= (supervisor_state == st_q) ? dwell + 16'h1 : 16'h1;
      good_cnt <= good_now ? good_cnt + 16'h1 : 16'h0;
      bad_cnt  <= (supervisor_state != BFS_RUN) ? bad_cnt + 16'h1 : 16'h0;
    end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_hs_trip_held;
    (high_side_gate && hs_overcurrent) [*3];
  endsequence
  sequence s_hiccup_done;
    supervisor_state == BFS_SOFT_START && st_q == BFS_HICCUP;
  endsequence
  sequence s_soft_done;
    supervisor_state == BFS_RUN && st_q == BFS_SOFT_START;
  endsequence
  chk_gate_overlap: assert property (!(high_side_gate && low_side_gate))
    else $error("Both gate enables high together");
  chk_gates_idle: assert property (!(supervisor_state inside
    {BFS_SOFT_START, BFS_RUN}) |-> !high_side_gate && !low_side_gate)
    else $error("Gate enabled outside soft start or run");
  chk_soft_flag: assert property (soft_start_active |->
    !$fell(output_ok_flag_oe)) else $error("Ok flag rose in soft start");
  chk_shutdown_off: assert property ((!disable_input_n ||
    !regulator_ok) [*4] |-> supervisor_state == BFS_OFF &&
    (regulator_ok || disable_input_n || !internal_regulator_en))
    else $error("Shutdown request not obeyed");
  chk_lockout_hold: assert property (!vin_above_lower [*5] |->
    !(supervisor_state inside {BFS_SOFT_START, BFS_RUN}))
    else $error("Running below lower input level");
  chk_ok_rise: assert property ($fell(output_ok_flag_oe) |->
    $past(good_cnt, 3) >= ASSERT_MIN) else $error("Ok flag rose early");
  chk_ok_fall: assert property (bad_cnt >= DEASSERT_LIM |->
    output_ok_flag_oe) else $error("Ok flag not dropped in time");
  chk_hs_cut: assert property (s_hs_trip_held |=> !high_side_gate)
    else $error("High gate not cut on overcurrent");
  chk_hiccup_len: assert property (s_hiccup_done |->
    dwell == HICCUP_CYC) else $error("Hiccup wait of wrong length");
  chk_soft_len: assert property (s_soft_done |-> dwell == SOFT_CYC)
    else $error("Soft start of wrong length");
endmodule

bind bfs_buck_fault_supervisor bfs_assertions #(
  .OK_ASSERT_CYC(OK_ASSERT_CYC), .HICCUP_CYC(HICCUP_CYC),
  .SOFT_CYC(SOFT_CYC)) u_chk (.pclk, .presetn, .disable_input_n,
  .vin_above_lower, .regulator_ok, .output_reached,
  .feedback_sense_in_window, .over_temp, .hs_overcurrent, .high_side_gate,
  .low_side_gate, .internal_regulator_en, .soft_start_active,
  .output_ok_flag_oe, .supervisor_state);

/* bfs_partner.sv */
// Model of the oscillator, switch node and overcurrent comparators
`timescale 1ns/1ps
module bfs_partner #(
  parameter int PERIOD = 20
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic high_side_gate,
  input  wire logic low_side_gate,
  input  wire logic trip_hs,
  input  wire logic trip_ls,
  output logic      osc_tick,
  output logic      pwm_high_request,
  output logic      phase_low,
  output logic      hs_overcurrent,
  output logic      ls_overcurrent
);
  int         ph;
  logic [1:0] hs_d;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph   <= 0;
      hs_d <= 2'h0;
    end
    else
    begin
      ph   <= (ph == PERIOD - 1) ? 0 : ph + 1;
      hs_d <= {hs_d[0], high_side_gate};
    end
  assign osc_tick = ph < 2;
  assign pwm_high_request = ph < PERIOD / 2;
  // Switch node lags the high gate, so adaptive mode really has to wait
  assign phase_low = !hs_d[1];
  // A comparator only sees current while its switch conducts
  assign hs_overcurrent = trip_hs && high_side_gate;
  assign ls_overcurrent = trip_ls && low_side_gate;
endmodule

/* testbench.sv */
// Self-checking testbench of the buck fault supervisor
`timescale 1ns/1ps
module testbench;
  import bfs_pkg::*;
  localparam int OKC = 20;
  localparam int HICC = 30;
  localparam int SOFTC = 40;
  localparam int PERIOD = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        disable_input_n, vin_above_upper, vin_above_lower;
  logic        regulator_ok, output_reached, feedback_sense_in_window;
  logic        over_temp, trip_hs, trip_ls, hs_overcurrent, ls_overcurrent;
  logic        pwm_high_request, osc_tick, phase_low, high_side_gate;
  logic        low_side_gate, internal_regulator_en, soft_start_active;
  logic        output_ok_flag_o, output_ok_flag_oe, ok_pin;
  bfs_state_t  supervisor_state;
  bfs_state_t  exp_tab [5] = '{BFS_OFF, BFS_OFF, BFS_LOCKOUT, BFS_OFF,
                              BFS_LOCKOUT};
  int          failures;
  int          check_count;
  bfs_buck_fault_supervisor #(.OK_ASSERT_CYC(OKC), .HICCUP_CYC(HICC),
    .SOFT_CYC(SOFTC)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .disable_input_n,
    .vin_above_upper, .vin_above_lower, .regulator_ok, .output_reached,
    .feedback_sense_in_window, .over_temp, .hs_overcurrent, .ls_overcurrent,
    .pwm_high_request, .osc_tick, .phase_low, .high_side_gate,
    .low_side_gate, .internal_regulator_en, .soft_start_active,
    .output_ok_flag_o, .output_ok_flag_oe, .supervisor_state);
  bfs_partner #(.PERIOD(PERIOD)) u_far (.pclk, .presetn, .high_side_gate,
    .low_side_gate, .trip_hs, .trip_ls, .osc_tick, .pwm_high_request,
    .phase_low, .hs_overcurrent, .ls_overcurrent);
  // Open drain pin with its pull-up
  assign ok_pin = output_ok_flag_oe ? output_ok_flag_o : 1'b1;
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(pready, 1'b1);
  endtask
  task automatic wait_st(input bfs_state_t s, input int lim);
    int n;
    n = 0;
    while (supervisor_state !== s && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic src(input int k, input logic bad);
    @(posedge pclk);
    case (k)
      0: disable_input_n <= !bad;
      1: regulator_ok <= !bad;
      2: over_temp <= bad;
      3: apb(1'b1, 12'h000, {31'h0, !bad});
      default:
      begin
        vin_above_upper <= !bad;
        vin_above_lower <= !bad;
      end
    endcase
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    int k;
    {failures, check_count, psel, penable, pwrite, paddr, pwdata} = '0;
    {disable_input_n, vin_above_lower, regulator_ok} = 3'h7;
    {output_reached, feedback_sense_in_window} = 2'h3;
    {vin_above_upper, over_temp, trip_hs, trip_ls} = 4'h0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    check(err, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    $display("Test registers done");
    repeat (10) @(negedge pclk);
    check(supervisor_state, BFS_LOCKOUT);
    src(4, 1'b0);
    wait_st(BFS_SOFT_START, 10);
    check(ok_pin, 1'b0);
    @(posedge pclk);
    vin_above_upper <= 1'b0;
    wait_st(BFS_RUN, SOFTC + 10);
    check(supervisor_state, BFS_RUN);
    repeat (OKC + 20) @(negedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[3:0], 4'hB);
    @(posedge pclk);
    feedback_sense_in_window <= 1'b0;
    repeat (100) @(negedge pclk);
    check(ok_pin, 1'b1);
    repeat (2950) @(negedge pclk);
    check(ok_pin, 1'b0);
    src(4, 1'b0);
    feedback_sense_in_window <= 1'b1;
    repeat (OKC + 20) @(negedge pclk);
    check(ok_pin, 1'b1);
    $display("Test lockout and flag done");
    for (k = 0; k < 2; k++)
    begin
      apb(1'b1, 12'h000, k ? 32'h3 : 32'h1);
      trip_hs <= (k == 0);
      trip_ls <= (k == 1);
      wait_st(BFS_HICCUP, 10 * PERIOD);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[2:0], BFS_HICCUP);
      check(k ? rd[14:12] : rd[10:8], 3'h7);
      check(rd[7:6], 2'h0);
      wait_st(BFS_SOFT_START, HICC + 10);
      wait_st(BFS_HICCUP, 3 * PERIOD);
      check(supervisor_state, BFS_HICCUP);
      @(posedge pclk);
      {trip_hs, trip_ls} <= 2'h0;
      wait_st(BFS_SOFT_START, HICC + 10);
      wait_st(BFS_RUN, SOFTC + 10);
      check(supervisor_state, BFS_RUN);
      repeat (8 * PERIOD) @(negedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      check({rd[14:12], rd[10:8], rd[5]}, 7'h0);
      $display("Test fault side %0d done", k);
    end
    for (k = 0; k < 5; k++)
    begin
      src(k, 1'b1);
      wait_st(exp_tab[k], 10);
      check(supervisor_state, exp_tab[k]);
      check({high_side_gate, low_side_gate}, 2'h0);
      check(internal_regulator_en, k != 0);
      src(k, 1'b0);
      wait_st(BFS_RUN, SOFTC + 20);
      check(supervisor_state, BFS_RUN);
    end
    $display("Test shutdown sources done");
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    conclude();
  end
endmodule
